// ### core/fcs_defs.svh
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

`define FCS_ADDR_W        21
`define FCS_DATA_W        16
`define FCS_CLK_MHZ       25
`define FCS_STROBE_NS     80
`define FCS_STROBE_CYC    (((`FCS_STROBE_NS * `FCS_CLK_MHZ) + 999) / 1000)
`define FCS_ERASE_TO_US   80
`define FCS_ERASE_TO_CYC  (`FCS_ERASE_TO_US * `FCS_CLK_MHZ)
`define FCS_SYNC_CYC      2
`define FCS_CNT_W         12

`define FCS_UNLOCK1_ADDR  18'h00555
`define FCS_UNLOCK2_ADDR  18'h002aa
`define FCS_CFI_ADDR      21'h000055
`define FCS_UNLOCK1_DATA  8'haa
`define FCS_UNLOCK2_DATA  8'h55
`define FCS_CODE_RESET    8'hf0
`define FCS_CODE_AUTOSEL  8'h90
`define FCS_CODE_SECENTR  8'h88
`define FCS_CODE_ZERO     8'h00
`define FCS_CODE_PROGRAM  8'ha0
`define FCS_CODE_BYPASS   8'h20
`define FCS_CODE_ERASE    8'h80
`define FCS_CODE_CHIPERS  8'h10
`define FCS_CODE_SECTERS  8'h30
`define FCS_CODE_SUSPEND  8'hb0
`define FCS_CODE_QUERY    8'h98

`define FCS_OFS_MANUF     18'h00000
`define FCS_OFS_DEV1      18'h00001
`define FCS_OFS_DEV2      18'h0000e
`define FCS_OFS_DEV3      18'h0000f
`define FCS_OFS_SECURED   18'h00003
`define FCS_OFS_PROTECT   12'h002

`define FCS_BANK_HI       20
`define FCS_BANK_LO       18
`define FCS_SECT_LO       12
`define FCS_TIMEOUT_BIT   5
`define FCS_TOGGLE_BIT    6

`endif

// ### core/fcs_pkg.sv
`include "fcs_defs.svh"

package fcs_pkg;

  typedef enum logic [4:0] {
    CMD_READ, CMD_RESET, CMD_ID_MANUF, CMD_ID_DEVICE, CMD_ID_SECURED, CMD_ID_PROTECT,
    CMD_SEC_ENTER, CMD_SEC_EXIT, CMD_PROGRAM, CMD_BYP_ENTER, CMD_BYP_PROGRAM,
    CMD_BYP_RESET, CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD, CMD_SUSPEND,
    CMD_RESUME, CMD_CFI_QUERY
  } fcs_cmd_type;

  typedef struct packed {
    fcs_cmd_type             cmd;
    logic [`FCS_ADDR_W-1:0]  addr;
    logic [`FCS_DATA_W-1:0]  data;
  } fcs_req_type;

  typedef struct packed {
    logic                    isWrite;
    logic                    last;
    logic [`FCS_ADDR_W-1:0]  addr;
    logic [`FCS_DATA_W-1:0]  data;
  } fcs_step_type;

  typedef struct packed {
    logic                    ceB;
    logic                    weB;
    logic                    oeB;
    logic                    dqOeB;
    logic [`FCS_ADDR_W-1:0]  addr;
    logic [`FCS_DATA_W-1:0]  dqOut;
  } fcs_pins_type;

endpackage : fcs_pkg

// ### core/fcs_host.sv
// What this block does
// - All command cycles are writes except array read and autoselect reads four to six.
// - Reset code F0 returns bank to read; host issues it after autoselect or timeout.
// - Autoselect: two unlocks, 90 at 555 in the bank, then read at bank (protect: sector) plus offset.
// - Host keeps the same bank address on autoselect reads until reset.
// - Device code is read over three reads at offsets 01, 0E and 0F.
// - Program is two unlocks, A0, then address with data.
// - Two-cycle bypass program is allowed only after bypass entry with code 20.
// - Bypass exit is 90 then 00 at any address.
// - Sector erase sixth cycle writes 30 at the sector address.
// - Secured region entry is two unlocks then 88.
// - Secured region exit is two unlocks, 90, then 00 anywhere.
// - Chip erase is two unlocks, 80, two unlocks, then 10.
`timescale 1ns/1ns
`include "fcs_defs.svh"

module fcs_host (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         reqValid,
  output logic                              reqReady,
  output logic                              reqRefused,
  input  wire fcs_pkg::fcs_req_type         req,
  output logic                              rspValid,
  output logic [`FCS_DATA_W-1:0]            rspData,
  output logic                              bypassMode,
  output logic                              opPending,
  output logic [`FCS_ADDR_W-1:0]            flashAddr,
  output logic [`FCS_DATA_W-1:0]            flashDqOut,
  output logic                              flashDqOe_b,
  input  wire logic [`FCS_DATA_W-1:0]       flashDqIn,
  output logic                              flashCe_b,
  output logic                              flashWe_b,
  output logic                              flashOe_b
);
  import fcs_pkg::*;

  localparam int STROBE_CYC = `FCS_STROBE_CYC;
  localparam int READ_CYC   = `FCS_STROBE_CYC + `FCS_SYNC_CYC;
  localparam int ERASE_CYC  = `FCS_ERASE_TO_CYC;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} fcs_state_type;

  fcs_state_type            stateFf, nxt_state;
  fcs_req_type              reqFf, nxt_req;
  logic [2:0]               idxFf, nxt_idx;
  logic [`FCS_CNT_W-1:0]    cntFf, nxt_cnt;
  logic [`FCS_CNT_W-1:0]    windowFf, nxt_window;
  fcs_pins_type             pinsFf, nxt_pins;
  logic                     bypassFf, nxt_bypass;
  logic                     eraseFf, nxt_erase;
  logic                     suspendFf, nxt_suspend;
  logic                     pendingFf, nxt_pending;
  logic                     lastToggleFf, nxt_lastToggle;
  logic                     haveToggleFf, nxt_haveToggle;
  logic                     rspValidFf, nxt_rspValid;
  logic [`FCS_DATA_W-1:0]   rspDataFf, nxt_rspData;
  logic [`FCS_DATA_W-1:0]   dqMeta, dqSync;
  fcs_step_type             step;
  logic                     legal;

  function automatic fcs_step_type wr(input logic [`FCS_ADDR_W-1:0] a,
                                      input logic [`FCS_DATA_W-1:0] d, input logic l);
    wr = '{isWrite: 1'b1, last: l, addr: a, data: d};
  endfunction : wr

  function automatic fcs_step_type rd(input logic [`FCS_ADDR_W-1:0] a, input logic l);
    rd = '{isWrite: 1'b0, last: l, addr: a, data: '0};
  endfunction : rd

  // Commands carry only the low byte; the upper byte and unused address bits go out as zero.
  function automatic fcs_step_type stepOf(input fcs_req_type r, input logic [2:0] i);
    logic [2:0]               bank;
    logic [`FCS_ADDR_W-1:0]   u1;
    logic [`FCS_ADDR_W-1:0]   u2;
    logic [`FCS_ADDR_W-1:0]   b555;
    logic [`FCS_ADDR_W-1:0]   ba;
    logic [`FCS_ADDR_W-1:0]   sa;
    fcs_step_type             s;
    fcs_step_type             ul1;
    fcs_step_type             ul2;
    bank = r.addr[`FCS_BANK_HI:`FCS_BANK_LO];
    u1   = {3'h0, `FCS_UNLOCK1_ADDR};
    u2   = {3'h0, `FCS_UNLOCK2_ADDR};
    b555 = {bank, `FCS_UNLOCK1_ADDR};
    ba   = {bank, 18'h00000};
    sa   = {r.addr[`FCS_BANK_HI:`FCS_SECT_LO], 12'h000};
    ul1  = wr(u1, {8'h00, `FCS_UNLOCK1_DATA}, 1'b0);
    ul2  = wr(u2, {8'h00, `FCS_UNLOCK2_DATA}, 1'b0);
    s    = wr('0, {8'h00, `FCS_CODE_RESET}, 1'b1);
    unique case (r.cmd)
      CMD_READ:        s = rd(r.addr, 1'b1);
      CMD_RESET:       s = wr('0, {8'h00, `FCS_CODE_RESET}, 1'b1);
      CMD_ID_MANUF, CMD_ID_DEVICE, CMD_ID_SECURED, CMD_ID_PROTECT: begin
        // The closing reset leaves autoselect; every read keeps the same bank bits.
        if (i == 3'd0) s = ul1;
        else if (i == 3'd1) s = ul2;
        else if (i == 3'd2) s = wr(b555, {8'h00, `FCS_CODE_AUTOSEL}, 1'b0);
        else if (i == 3'd3) begin
          unique case (r.cmd)
            CMD_ID_MANUF:   s = rd({bank, `FCS_OFS_MANUF}, 1'b0);
            CMD_ID_DEVICE:  s = rd({bank, `FCS_OFS_DEV1}, 1'b0);
            CMD_ID_SECURED: s = rd({bank, `FCS_OFS_SECURED}, 1'b0);
            default:        s = rd({sa[`FCS_ADDR_W-1:`FCS_SECT_LO], `FCS_OFS_PROTECT}, 1'b0);
          endcase
        end
        else if (i == 3'd4 && r.cmd == CMD_ID_DEVICE) s = rd({bank, `FCS_OFS_DEV2}, 1'b0);
        else if (i == 3'd5 && r.cmd == CMD_ID_DEVICE) s = rd({bank, `FCS_OFS_DEV3}, 1'b0);
        else s = wr('0, {8'h00, `FCS_CODE_RESET}, 1'b1);
      end
      CMD_SEC_ENTER, CMD_SEC_EXIT, CMD_PROGRAM, CMD_BYP_ENTER: begin
        if (i == 3'd0) s = ul1;
        else if (i == 3'd1) s = ul2;
        else if (i == 3'd2) begin
          unique case (r.cmd)
            CMD_SEC_ENTER: s = wr(u1, {8'h00, `FCS_CODE_SECENTR}, 1'b1);
            CMD_SEC_EXIT:  s = wr(u1, {8'h00, `FCS_CODE_AUTOSEL}, 1'b0);
            CMD_PROGRAM:   s = wr(u1, {8'h00, `FCS_CODE_PROGRAM}, 1'b0);
            default:       s = wr(u1, {8'h00, `FCS_CODE_BYPASS}, 1'b1);
          endcase
        end
        else if (r.cmd == CMD_SEC_EXIT) s = wr('0, {8'h00, `FCS_CODE_ZERO}, 1'b1);
        else s = wr(r.addr, r.data, 1'b1);
      end
      CMD_BYP_PROGRAM: s = (i == 3'd0) ? wr('0, {8'h00, `FCS_CODE_PROGRAM}, 1'b0)
                                       : wr(r.addr, r.data, 1'b1);
      CMD_BYP_RESET:   s = (i == 3'd0) ? wr('0, {8'h00, `FCS_CODE_AUTOSEL}, 1'b0)
                                       : wr('0, {8'h00, `FCS_CODE_ZERO}, 1'b1);
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE: begin
        if (i == 3'd0 || i == 3'd3) s = ul1;
        else if (i == 3'd1 || i == 3'd4) s = ul2;
        else if (i == 3'd2) s = wr(u1, {8'h00, `FCS_CODE_ERASE}, 1'b0);
        else if (r.cmd == CMD_CHIP_ERASE) s = wr(u1, {8'h00, `FCS_CODE_CHIPERS}, 1'b1);
        else s = wr(sa, {8'h00, `FCS_CODE_SECTERS}, 1'b1);
      end
      CMD_SECTOR_ADD:  s = wr(sa, {8'h00, `FCS_CODE_SECTERS}, 1'b1);
      CMD_SUSPEND:     s = wr(ba, {8'h00, `FCS_CODE_SUSPEND}, 1'b1);
      CMD_RESUME:      s = wr(ba, {8'h00, `FCS_CODE_SECTERS}, 1'b1);
      CMD_CFI_QUERY:   s = wr(`FCS_CFI_ADDR, {8'h00, `FCS_CODE_QUERY}, 1'b1);
    endcase
    stepOf = s;
  endfunction : stepOf

  // Requests that the flash would ignore or misread are refused before any pin moves.
  always_comb begin
    unique case (req.cmd)
      CMD_READ:        legal = 1'b1;
      CMD_BYP_PROGRAM: legal = bypassFf;
      CMD_BYP_RESET:   legal = bypassFf;
      CMD_SECTOR_ADD:  legal = !bypassFf && windowFf != '0;
      CMD_SUSPEND:     legal = !bypassFf && eraseFf && !suspendFf;
      CMD_RESUME:      legal = !bypassFf && suspendFf;
      CMD_CFI_QUERY:   legal = !bypassFf && !eraseFf;
      default:         legal = !bypassFf;
    endcase
  end

  assign step       = stepOf(reqFf, idxFf);
  assign reqReady   = (stateFf == ST_IDLE);
  assign reqRefused = reqReady && reqValid && !legal;

  always_comb begin
    nxt_state      = stateFf;
    nxt_req        = reqFf;
    nxt_idx        = idxFf;
    nxt_cnt        = cntFf;
    nxt_window     = (windowFf != '0) ? windowFf - 1'b1 : windowFf;
    nxt_pins       = pinsFf;
    nxt_bypass     = bypassFf;
    nxt_erase      = eraseFf;
    nxt_suspend    = suspendFf;
    nxt_pending    = pendingFf;
    nxt_lastToggle = lastToggleFf;
    nxt_haveToggle = haveToggleFf;
    nxt_rspValid   = 1'b0;
    nxt_rspData    = rspDataFf;
    unique case (stateFf)
      ST_IDLE: begin
        if (reqValid && legal) begin
          nxt_req   = req;
          nxt_idx   = 3'd0;
          nxt_state = ST_SETUP;
          // Any command other than another sector or a suspend closes the erase loading window.
          if (req.cmd != CMD_SECTOR_ADD && req.cmd != CMD_SUSPEND) nxt_window = '0;
        end
      end
      ST_SETUP: begin
        // Address settles with chip enable low before the strobe falls.
        nxt_pins.ceB   = 1'b0;
        nxt_pins.addr  = step.addr;
        nxt_pins.dqOut = step.data;
        nxt_pins.dqOeB = !step.isWrite;
        nxt_cnt        = '0;
        nxt_state      = ST_STROBE;
      end
      ST_STROBE: begin
        nxt_pins.weB = !step.isWrite;
        nxt_pins.oeB = step.isWrite;
        nxt_cnt      = cntFf + 1'b1;
        if (step.isWrite ? (cntFf == STROBE_CYC[`FCS_CNT_W-1:0])
                         : (cntFf == READ_CYC[`FCS_CNT_W-1:0])) begin
          // Data stays driven through the rising strobe and one more cycle.
          nxt_pins.weB = 1'b1;
          nxt_pins.oeB = 1'b1;
          nxt_state    = ST_HOLD;
          if (!step.isWrite) begin
            nxt_rspValid = 1'b1;
            nxt_rspData  = dqSync;
            if (reqFf.cmd == CMD_READ && pendingFf) begin
              nxt_lastToggle = dqSync[`FCS_TOGGLE_BIT];
              nxt_haveToggle = 1'b1;
              if (haveToggleFf && lastToggleFf == dqSync[`FCS_TOGGLE_BIT]) begin
                nxt_pending    = 1'b0;
                nxt_haveToggle = 1'b0;
                if (!suspendFf) nxt_erase = 1'b0;
              end else if (dqSync[`FCS_TIMEOUT_BIT]) begin
                // Still toggling with the timeout bit up: a reset follows at once.
                nxt_req.cmd    = CMD_RESET;
                nxt_pending    = 1'b0;
                nxt_erase      = 1'b0;
                nxt_suspend    = 1'b0;
                nxt_haveToggle = 1'b0;
              end
            end
          end
        end
      end
      ST_HOLD: begin
        nxt_pins.ceB   = 1'b1;
        nxt_pins.dqOeB = 1'b1;
        if (step.last && !(reqFf.cmd == CMD_RESET && pinsFf.dqOeB)) begin
          nxt_state = ST_IDLE;
          unique case (reqFf.cmd)
            CMD_BYP_ENTER:   nxt_bypass = 1'b1;
            CMD_BYP_RESET:   nxt_bypass = 1'b0;
            CMD_PROGRAM, CMD_BYP_PROGRAM, CMD_CHIP_ERASE: nxt_pending = 1'b1;
            CMD_SECTOR_ERASE, CMD_SECTOR_ADD: begin
              nxt_pending = 1'b1;
              nxt_erase   = 1'b1;
              nxt_window  = ERASE_CYC[`FCS_CNT_W-1:0];
            end
            CMD_SUSPEND:     nxt_suspend = 1'b1;
            CMD_RESUME:      nxt_suspend = 1'b0;
            default:         nxt_pending = pendingFf;
          endcase
        end else begin
          nxt_idx   = (step.last) ? 3'd0 : idxFf + 1'b1;
          nxt_state = ST_SETUP;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    dqMeta <= flashDqIn;
    dqSync <= dqMeta;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stateFf      <= ST_IDLE;
      reqFf        <= '0;
      idxFf        <= 3'd0;
      cntFf        <= '0;
      windowFf     <= '0;
      pinsFf       <= '{ceB: 1'b1, weB: 1'b1, oeB: 1'b1, dqOeB: 1'b1, addr: '0, dqOut: '0};
      bypassFf     <= 1'b0;
      eraseFf      <= 1'b0;
      suspendFf    <= 1'b0;
      pendingFf    <= 1'b0;
      lastToggleFf <= 1'b0;
      haveToggleFf <= 1'b0;
      rspValidFf   <= 1'b0;
      rspDataFf    <= '0;
    end else begin
      stateFf      <= nxt_state;
      reqFf        <= nxt_req;
      idxFf        <= nxt_idx;
      cntFf        <= nxt_cnt;
      windowFf     <= nxt_window;
      pinsFf       <= nxt_pins;
      bypassFf     <= nxt_bypass;
      eraseFf      <= nxt_erase;
      suspendFf    <= nxt_suspend;
      pendingFf    <= nxt_pending;
      lastToggleFf <= nxt_lastToggle;
      haveToggleFf <= nxt_haveToggle;
      rspValidFf   <= nxt_rspValid;
      rspDataFf    <= nxt_rspData;
    end
  end

  // A sequence is never left half written except by rst_b, which idles the pins and can leave the flash mid-command.
  assign flashAddr   = pinsFf.addr;
  assign flashDqOut  = pinsFf.dqOut;
  assign flashDqOe_b = pinsFf.dqOeB;
  assign flashCe_b   = pinsFf.ceB;
  assign flashWe_b   = pinsFf.weB;
  assign flashOe_b   = pinsFf.oeB;
  assign rspValid    = rspValidFf;
  assign rspData     = rspDataFf;
  assign bypassMode  = bypassFf;
  assign opPending   = pendingFf;

endmodule : fcs_host

// ### verification/fcs_host_monitor.sv
`timescale 1ns/1ns
`include "fcs_defs.svh"
module fcs_host_monitor (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   reqValid,
  input wire logic                   reqReady,
  input wire logic                   reqRefused,
  input wire fcs_pkg::fcs_req_type   req,
  input wire logic                   rspValid,
  input wire logic [`FCS_DATA_W-1:0] rspData,
  input wire logic                   bypassMode,
  input wire logic                   opPending,
  input wire logic [`FCS_ADDR_W-1:0] flashAddr,
  input wire logic [`FCS_DATA_W-1:0] flashDqOut,
  input wire logic                   flashDqOe_b,
  input wire logic [`FCS_DATA_W-1:0] flashDqIn,
  input wire logic                   flashCe_b,
  input wire logic                   flashWe_b,
  input wire logic                   flashOe_b
);
  import fcs_pkg::*;
  logic take;
  assign take = reqValid && reqReady;
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence weLow2;
    !flashWe_b [*2] ##1 flashWe_b;
  endsequence
  sequence busStart;
    !reqReady ##[0:1] !flashCe_b;
  endsequence
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !rst_b |=> flashCe_b && flashWe_b && flashOe_b && flashDqOe_b && !rspValid)
    else $error("Bus not idle after reset");
  AST_TAKE_STARTS: assert property (take && !reqRefused |=> busStart)
    else $error("Accepted request did not start a bus cycle");
  AST_REFUSE_QUIET: assert property (take && reqRefused |=> reqReady && flashCe_b)
    else $error("Refused request moved the bus");
  AST_BYP_ONLY: assert property (bypassMode && take &&
    !(req.cmd inside {CMD_READ, CMD_BYP_PROGRAM, CMD_BYP_RESET}) |-> reqRefused)
    else $error("Command accepted in bypass mode");
  AST_BYP_NEEDED: assert property (!bypassMode && take &&
    req.cmd inside {CMD_BYP_PROGRAM, CMD_BYP_RESET} |-> reqRefused)
    else $error("Bypass command accepted outside bypass mode");
  AST_WE_WIDTH: assert property ($fell(flashWe_b) |-> weLow2)
    else $error("Write strobe width wrong");
  AST_WE_FRAME: assert property (!flashWe_b |->
    !flashCe_b && flashOe_b && !flashDqOe_b && $stable(flashAddr))
    else $error("Write strobe outside a framed write");
  AST_OE_FRAME: assert property (!flashOe_b |-> !flashCe_b && flashWe_b && flashDqOe_b)
    else $error("Read strobe outside a framed read");
  AST_RSP_AFTER_OE: assert property ($rose(flashOe_b) |-> ##[0:2] rspValid)
    else $error("Read word not reported");
  AST_RSP_PULSE: assert property (rspValid |=> !rspValid)
    else $error("Read pulse too long");
  AST_BUSY: assert property (!flashCe_b |-> !reqReady)
    else $error("Ready during a bus cycle");
endmodule : fcs_host_monitor

bind fcs_host fcs_host_monitor mon (.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
  .reqReady(reqReady), .reqRefused(reqRefused), .req(req), .rspValid(rspValid),
  .rspData(rspData), .bypassMode(bypassMode), .opPending(opPending), .flashAddr(flashAddr),
  .flashDqOut(flashDqOut), .flashDqOe_b(flashDqOe_b), .flashDqIn(flashDqIn),
  .flashCe_b(flashCe_b), .flashWe_b(flashWe_b), .flashOe_b(flashOe_b));

// ### verification/fcs_flash_model.sv
`timescale 1ns/1ns
module fcs_flash_model #(
  parameter logic [15:0] MANUF_ID = 16'h00c3, // Arbitrary value.
  parameter logic [15:0] DEV_ID   = 16'h7e50  // Arbitrary value.
) (
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq,
  output logic      [15:0] dqOut,
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic        oe_b
);
  logic [15:0] mem [logic [20:0]];
  logic [20:0] la;
  logic [15:0] last = 16'h0000;
  logic [2:0]  selBank = 3'h0;
  logic        autoSel = 0, bypass = 0, secured = 0, exitArm = 0, erasing = 0;
  logic        suspended = 0, chipErased = 0, cfi = 0, toggle = 0;
  int          seq = 0, busy = 0, sectCnt = 0, errCnt = 0;
  initial dqOut = 16'h0000;
  always @(negedge we_b or negedge ce_b) if (!we_b && !ce_b) la = addr;
  // Only the first rising strobe edge finds the other strobe still low.
  always @(posedge we_b or posedge ce_b) if (we_b != ce_b) wr(la, dq);
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    logic [10:0] lo;
    logic [7:0]  c;
    lo = a[10:0];
    c = d[7:0];
    if (seq == 3 || seq == 7) begin
      mem[a] = d;
      busy = 4;
      seq = 0;
    end else if (c == 8'hf0) begin
      autoSel = 0;
      cfi = 0;
      seq = 0;
    end else case (seq)
      0: if (lo == 11'h555 && c == 8'haa) seq = 1;
         else if (bypass && c == 8'ha0) seq = 7;
         else if (bypass && c == 8'h90) seq = 8;
         else if (c == 8'hb0 && erasing) {suspended, erasing} = 2'b10;
         else if (c == 8'h30 && suspended) {suspended, erasing} = 2'b01;
         else if (c == 8'h30 && erasing) sectCnt++;
         else if (c == 8'h98 && lo == 11'h055 && !erasing) cfi = 1;
         else if (c == 8'h00 && exitArm) {secured, autoSel, exitArm} = 3'b000;
      1: seq = (lo == 11'h2aa && c == 8'h55) ? 2 : 0;
      2: begin
        seq = 0;
        if (lo == 11'h555) case (c)
          8'h90: {autoSel, selBank, exitArm} = {1'b1, a[20:18], secured};
          8'ha0: seq = 3;
          8'h20: bypass = 1;
          8'h88: secured = 1;
          8'h80: seq = 4;
          default: ;
        endcase
      end
      4: seq = (lo == 11'h555 && c == 8'haa) ? 5 : 0;
      5: seq = (lo == 11'h2aa && c == 8'h55) ? 6 : 0;
      6: begin
        seq = 0;
        if (c == 8'h10) {chipErased, busy} = {1'b1, 32'd4};
        if (c == 8'h10) mem.delete();
        if (c == 8'h30) {erasing, sectCnt, busy} = {1'b1, 32'd1, 32'd4};
      end
      8: begin
        seq = 0;
        if (c == 8'h00) bypass = 0;
      end
      default: seq = 0;
    endcase
  endtask
  always @(negedge oe_b) begin
    if (autoSel) begin
      if (addr[20:18] != selBank) errCnt++;
      case (addr[7:0])
        8'h00: last = MANUF_ID;
        8'h01, 8'h0e, 8'h0f: last = DEV_ID + {8'h00, addr[7:0]};
        8'h03: last = 16'h0082;
        8'h02: last = 16'h0000;
        default: last = 16'hffff;
      endcase
    end else if (busy > 0 && !suspended) begin
      toggle = !toggle;
      busy--;
      if (busy == 0) erasing = 0;
      last = {9'h000, toggle, 6'h00};
    end else last = mem.exists(addr) ? mem[addr] : 16'hffff;
    dqOut = last;
  end
  // A released bus shows the inverse so a stale value is never mistaken for data.
  always @(posedge oe_b) dqOut = ~last;
endmodule : fcs_flash_model

// ### verification/tb_flash_command_sequence_decoder.sv
`timescale 1ns/1ns
module tb_flash_command_sequence_decoder;
  import fcs_pkg::*;
  logic        core_clk = 0, rst_b, reqValid, reqReady, reqRefused, rspValid, bypassMode;
  logic        opPending, flashDqOe_b, flashCe_b, flashWe_b, flashOe_b;
  logic [15:0] rspData, flashDqOut, flashDqIn, modelDq;
  logic [20:0] flashAddr;
  fcs_req_type req;
  int          bad_count, tests_run;
  logic [15:0] rsp [$];
  assign flashDqIn = flashDqOe_b ? modelDq : flashDqOut;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (rspValid === 1'b1) rsp.push_back(rspData);
  fcs_host uut (.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady),
    .reqRefused(reqRefused), .req(req), .rspValid(rspValid), .rspData(rspData),
    .bypassMode(bypassMode), .opPending(opPending), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe_b(flashDqOe_b), .flashDqIn(flashDqIn),
    .flashCe_b(flashCe_b), .flashWe_b(flashWe_b), .flashOe_b(flashOe_b));
  fcs_flash_model #(.MANUF_ID(16'h00c3), .DEV_ID(16'h7e50)) pm (.addr(flashAddr),
    .dq(flashDqIn), .dqOut(modelDq), .ce_b(flashCe_b), .we_b(flashWe_b), .oe_b(flashOe_b));
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic send(input fcs_cmd_type c, input logic [20:0] a, input logic [15:0] d,
                      input logic expRef, input string what);
    int   n;
    logic refd;
    n = 0;
    @(posedge core_clk);
    #1 reqValid = 1;
    req = '{cmd: c, addr: a, data: d};
    @(negedge core_clk);
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 50, "request never offered");
    refd = reqRefused;
    @(posedge core_clk);
    #1 reqValid = 0;
    check(refd === expRef, what);
    n = 0;
    @(negedge core_clk);
    while (reqReady !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 400, "sequence never finished");
    repeat (2) @(posedge core_clk);
  endtask : send
  task automatic poll(input logic [20:0] a);
    int n;
    n = 0;
    while (opPending === 1'b1 && n < 20) begin
      send(CMD_READ, a, 16'h0000, 1'b0, "status read");
      n++;
    end
    check(opPending === 1'b0, "operation never finished");
  endtask : poll
  task automatic readv(input logic [20:0] a, input logic [15:0] exp, input string what);
    rsp.delete();
    send(CMD_READ, a, 16'h0000, 1'b0, what);
    check(rsp.size() == 1 && rsp[0] === exp, what);
  endtask : readv
  task automatic t_program;
    send(CMD_PROGRAM, 21'h0a1234, 16'hbeef, 1'b0, "program");
    poll(21'h0a1234);
    readv(21'h0a1234, 16'hbeef, "program readback");
    readv(21'h1f0000, 16'hffff, "blank read");
  endtask : t_program
  task automatic t_ident;
    rsp.delete();
    send(CMD_ID_MANUF, 21'h040000, 16'h0000, 1'b0, "manufacturer id");
    check(rsp.size() == 1 && rsp[0][7:0] === 8'hc3, "manufacturer code");
    rsp.delete();
    send(CMD_ID_DEVICE, 21'h040000, 16'h0000, 1'b0, "device id");
    check(rsp.size() == 3 && rsp[0][7:0] === 8'h51 && rsp[1][7:0] === 8'h5e
          && rsp[2][7:0] === 8'h5f, "device code words");
    rsp.delete();
    send(CMD_ID_SECURED, 21'h040000, 16'h0000, 1'b0, "secured id");
    check(rsp.size() == 1 && rsp[0][7:0] === 8'h82, "secured indicator");
    rsp.delete();
    send(CMD_ID_PROTECT, 21'h045000, 16'h0000, 1'b0, "protect id");
    check(rsp.size() == 1 && rsp[0][7:0] === 8'h00, "protect verify");
    check(pm.errCnt == 0 && pm.autoSel === 1'b0, "autoselect bank or exit");
    readv(21'h0a1234, 16'hbeef, "read after autoselect");
  endtask : t_ident
  task automatic t_bypass;
    send(CMD_BYP_PROGRAM, 21'h001000, 16'h1234, 1'b1, "bypass program outside");
    send(CMD_BYP_RESET, 21'h000000, 16'h0000, 1'b1, "bypass exit outside");
    send(CMD_BYP_ENTER, 21'h000000, 16'h0000, 1'b0, "bypass enter");
    check(bypassMode === 1'b1 && pm.bypass === 1'b1, "bypass entered");
    send(CMD_PROGRAM, 21'h001000, 16'h1234, 1'b1, "full program in bypass");
    send(CMD_BYP_PROGRAM, 21'h001000, 16'h5a0f, 1'b0, "bypass program");
    poll(21'h001000);
    readv(21'h001000, 16'h5a0f, "bypass readback");
    send(CMD_BYP_RESET, 21'h000000, 16'h0000, 1'b0, "bypass exit");
    check(bypassMode === 1'b0 && pm.bypass === 1'b0, "bypass left");
  endtask : t_bypass
  task automatic t_secure;
    send(CMD_SEC_ENTER, 21'h000000, 16'h0000, 1'b0, "secured enter");
    check(pm.secured === 1'b1, "secured region entered");
    send(CMD_SEC_EXIT, 21'h000000, 16'h0000, 1'b0, "secured exit");
    check(pm.secured === 1'b0 && pm.autoSel === 1'b0, "secured region left");
  endtask : t_secure
  task automatic t_erase;
    send(CMD_SUSPEND, 21'h040000, 16'h0000, 1'b1, "suspend without erase");
    send(CMD_RESUME, 21'h040000, 16'h0000, 1'b1, "resume without suspend");
    send(CMD_SECTOR_ERASE, 21'h045000, 16'h0000, 1'b0, "sector erase");
    check(pm.erasing === 1'b1, "sector erase started");
    send(CMD_CFI_QUERY, 21'h000000, 16'h0000, 1'b1, "query during erase");
    send(CMD_SECTOR_ADD, 21'h046000, 16'h0000, 1'b0, "sector add");
    check(pm.sectCnt == 2, "second sector taken");
    repeat (2100) @(posedge core_clk);
    send(CMD_SECTOR_ADD, 21'h047000, 16'h0000, 1'b1, "late sector add");
    send(CMD_SUSPEND, 21'h040000, 16'h0000, 1'b0, "suspend");
    check(pm.suspended === 1'b1, "erase suspended");
    send(CMD_SUSPEND, 21'h040000, 16'h0000, 1'b1, "second suspend");
    send(CMD_RESUME, 21'h040000, 16'h0000, 1'b0, "resume");
    check(pm.erasing === 1'b1 && pm.suspended === 1'b0, "erase resumed");
    poll(21'h045000);
  endtask : t_erase
  task automatic t_chip;
    send(CMD_CHIP_ERASE, 21'h000000, 16'h0000, 1'b0, "chip erase");
    check(pm.chipErased === 1'b1, "chip erase started");
    poll(21'h0a1234);
    readv(21'h0a1234, 16'hffff, "erased readback");
    send(CMD_CFI_QUERY, 21'h000000, 16'h0000, 1'b0, "query when ready");
    check(pm.cfi === 1'b1, "query accepted");
  endtask : t_chip
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_b = 0;
    reqValid = 0;
    req = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge core_clk);
    #1 rst_b = 1;
    t_program();
    t_ident();
    t_bypass();
    t_secure();
    t_erase();
    t_chip();
    wrap_up();
  end
endmodule : tb_flash_command_sequence_decoder
